// ---- dssd_pkg.sv ----
/*
  Constants and types for the drive spin-up strap decoder.
  Assumes a 50 MHz system clock.
*/
package dssd_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int SEAT_DELAY_MS = 250;
  localparam int SEAT_DELAY_CYC = (SEAT_DELAY_MS * (CLK_HZ / 1000));
  localparam int SPIN_STEP_S = 12;
  localparam int SPIN_STEP_CYC_DEF = 600000000;
  localparam int MAX_DELAY_S = 12;
  localparam int CNT_W = 32;
  localparam int ADDR_W = 4;
  localparam int NARROW_MAX_ADDR = 7;
  localparam int FLASH_HALF_CYC_DEF = 12500000;
  typedef enum logic [1:0] {
    DSSD_SPIN_IMMEDIATE,
    DSSD_SPIN_COMMAND,
    DSSD_SPIN_DELAYED
  } dssd_spin_mode_t;
endpackage

// ---- dssd_sync.sv ----
/*
  Two-flop synchroniser for a vector of pin inputs.
  Assumes inputs are asynchronous to clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none
module dssd_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } dssd_sync_state_t;
  dssd_sync_state_t state;
  dssd_sync_state_t next_state;

  always_comb begin
    next_state.meta = async_in;
    next_state.stable = state.meta;
  end

  // Reset to the open level, so that no strap or seat reads grounded before the pins are seen
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= '1;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.stable;
endmodule // dssd_sync
`default_nettype wire

// ---- dssd_top.sv ----
/*
  Strap decoder and motor spin-up sequencer with activity indicator.
  Assumes strap pins and seated sense arrive asynchronously; command and
  flash requests come from logic on clk_sys. Strap pins read 1 when open.
*/
`timescale 1ns/10ps
`default_nettype none
module dssd_top #(
  parameter bit WIDE_BUS = 1'b0,
  parameter int SEAT_DELAY_CYC = dssd_pkg::SEAT_DELAY_CYC,
  parameter int SPIN_STEP_CYC = dssd_pkg::SPIN_STEP_CYC_DEF,
  parameter int FLASH_HALF_CYC = dssd_pkg::FLASH_HALF_CYC_DEF
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [3:0] address_straps,
  input wire logic delayed_start_strap,
  input wire logic remote_start_strap,
  input wire logic seated_sense_n,
  input wire logic start_unit_cmd,
  input wire logic command_active,
  input wire logic flash_request,
  output logic [3:0] strap_address,
  output logic [1:0] spin_mode,
  output logic straps_valid,
  output logic motor_spin_en,
  output logic activity_indicator_out_n
);
  // --------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------
  logic [6:0] pins_sync;
  dssd_sync #(.WIDTH(7)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in({seated_sense_n, remote_start_strap, delayed_start_strap, address_straps}),
    .sync_out(pins_sync)
  );

  typedef enum logic [1:0] {
    DSSD_WAIT_SEAT,
    DSSD_SETTLE,
    DSSD_DELAY,
    DSSD_RUN
  } dssd_phase_t;

  typedef struct packed {
    dssd_phase_t phase;
    logic [dssd_pkg::CNT_W-1:0] timer;
    logic [3:0] steps_left;
    logic [3:0] addr;
    dssd_pkg::dssd_spin_mode_t mode;
    logic valid;
    logic spin;
    logic [dssd_pkg::CNT_W-1:0] flash_cnt;
    logic flash_phase;
    logic led_on;
  } dssd_state_t;

  dssd_state_t state;
  dssd_state_t next_state;

  logic [3:0] raw_addr;
  logic dly_gnd;
  logic rmt_gnd;
  logic seated;
  assign raw_addr = ~pins_sync[3:0];
  assign dly_gnd = ~pins_sync[4];
  assign rmt_gnd = ~pins_sync[5];
  assign seated = ~pins_sync[6];

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state.phase)
      DSSD_WAIT_SEAT: begin
        next_state.timer = '0;
        if (seated) begin
          next_state.phase = DSSD_SETTLE;
        end
      end
      DSSD_SETTLE: begin
        // A seat bounce restarts the settle wait
        if (!seated) begin
          next_state.phase = DSSD_WAIT_SEAT;
        end else if (state.timer >= dssd_pkg::CNT_W'(SEAT_DELAY_CYC - 1)) begin
          next_state.timer = '0;
          next_state.valid = 1'b1;
          // Narrow build ignores strap 3 rather than claim an unsupported address
          next_state.addr = WIDE_BUS ? raw_addr : {1'b0, raw_addr[2:0]};
          next_state.steps_left = next_state.addr;
          if (!dly_gnd && !rmt_gnd) begin
            next_state.mode = dssd_pkg::DSSD_SPIN_IMMEDIATE;
            next_state.spin = 1'b1;
            next_state.phase = DSSD_RUN;
          end else if (dly_gnd && !rmt_gnd) begin
            next_state.mode = dssd_pkg::DSSD_SPIN_DELAYED;
            next_state.phase = DSSD_DELAY;
          end else begin
            next_state.mode = dssd_pkg::DSSD_SPIN_COMMAND;
            next_state.phase = DSSD_RUN;
          end
        end else begin
          next_state.timer = state.timer + 1'b1;
        end
      end
      DSSD_DELAY: begin
        // Step length is a parameter so a shorter multiplier can be built in
        if (state.steps_left == 4'h0) begin
          next_state.spin = 1'b1;
          next_state.phase = DSSD_RUN;
        end else if (state.timer >= dssd_pkg::CNT_W'(SPIN_STEP_CYC - 1)) begin
          next_state.timer = '0;
          next_state.steps_left = state.steps_left - 4'h1;
        end else begin
          next_state.timer = state.timer + 1'b1;
        end
      end
      DSSD_RUN: begin
        if (start_unit_cmd) begin
          next_state.spin = 1'b1;
        end
      end
      default: begin
        next_state.phase = DSSD_WAIT_SEAT;
      end
    endcase

    // --------------------------------------------------------------
    // Activity indicator
    // --------------------------------------------------------------
    if (flash_request) begin
      if (state.flash_cnt >= dssd_pkg::CNT_W'(FLASH_HALF_CYC - 1)) begin
        next_state.flash_cnt = '0;
        next_state.flash_phase = ~state.flash_phase;
      end else begin
        next_state.flash_cnt = state.flash_cnt + 1'b1;
      end
    end else begin
      next_state.flash_cnt = '0;
      next_state.flash_phase = 1'b0;
    end
    // Steady command indication overrides any flash pattern
    next_state.led_on = command_active | (flash_request & next_state.flash_phase);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= '{phase: DSSD_WAIT_SEAT, mode: dssd_pkg::DSSD_SPIN_COMMAND, default: '0};
    end else begin
      state <= next_state;
    end
  end

  assign strap_address = state.addr;
  assign spin_mode = state.mode;
  assign straps_valid = state.valid;
  assign motor_spin_en = state.spin;
  assign activity_indicator_out_n = ~state.led_on;
endmodule // dssd_top
`default_nettype wire

// ---- dssd_backplane.sv ----
/* Backplane strap wiring for one slot.
   Assumes the bench picks which straps are grounded and when the slot is seated. */
`timescale 1ns/10ps
`default_nettype none
module dssd_backplane (
  input wire logic [3:0] gnd_addr,
  input wire logic [1:0] gnd_start,
  input wire logic seated,
  output logic [3:0] address_straps,
  output logic delayed_start_strap,
  output logic remote_start_strap,
  output logic seated_sense_n
);
  // Own copy per slot: a bussed open strap could be clamped by a dead drive
  assign address_straps = ~gnd_addr;
  assign delayed_start_strap = ~gnd_start[1];
  assign remote_start_strap = ~gnd_start[0];
  assign seated_sense_n = ~seated;
endmodule // dssd_backplane
`default_nettype wire

// ---- dssd_top_properties.sv ----
/* Port checker for dssd_top, bound below.
   Assumes one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module dssd_top_properties #(parameter int SPIN_STEP_CYC = 5) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic start_unit_cmd,
  input wire logic command_active,
  input wire logic flash_request,
  input wire logic [3:0] strap_address,
  input wire logic [1:0] spin_mode,
  input wire logic straps_valid,
  input wire logic motor_spin_en,
  input wire logic activity_indicator_out_n
);
  logic [31:0] held;
  wire logic cmd_mode = straps_valid && spin_mode == 2'h1;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // Cycles since the latch, to time the delayed start
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) held <= 32'h0;
    else if (straps_valid) held <= held + 32'h1;
  end
  lamp_on_a: assert property (command_active |=> !activity_indicator_out_n) else $error("lamp off");
  lamp_idle_a: assert property ((!command_active && !flash_request) [*2]
    |=> activity_indicator_out_n) else $error("lamp on");
  latch_hold_a: assert property (straps_valid |=> straps_valid && $stable({strap_address, spin_mode}))
    else $error("latch moved");
  early_spin_a: assert property (!straps_valid |-> !motor_spin_en) else $error("early spin");
  cmd_wait_a: assert property (cmd_mode && !start_unit_cmd && !motor_spin_en |=> !motor_spin_en)
    else $error("spun unasked");
  cmd_go_a: assert property (cmd_mode && start_unit_cmd |=> motor_spin_en) else $error("no start");
  now_spin_a: assert property ($rose(straps_valid) && spin_mode == 2'h0 |-> motor_spin_en) else $error("late");
  delay_len_a: assert property ($rose(motor_spin_en) && spin_mode == 2'h2
    |-> held == strap_address * SPIN_STEP_CYC + 1) else $error("bad delay");
  cover property ($rose(motor_spin_en) && spin_mode == 2'h2);
  cover property (cmd_mode && start_unit_cmd);
  cover property (flash_request && !activity_indicator_out_n);
endmodule // dssd_top_properties
bind dssd_top dssd_top_properties #(.SPIN_STEP_CYC(SPIN_STEP_CYC)) i_props (.clk_sys, .reset_n, .start_unit_cmd,
  .command_active, .flash_request, .strap_address, .spin_mode, .straps_valid, .motor_spin_en,
  .activity_indicator_out_n);
`default_nettype wire

// ---- test_drive_spinup_strap_decoder.sv ----
/* Bench booting the decoder under each strap case.
   Assumes settle 10, step 5, flash half period 4. */
`timescale 1ns/10ps
`default_nettype none
module test_drive_spinup_strap_decoder;
  logic clk_sys = 1'b0, reset_n = 1'b0, start_unit_cmd = 1'b0, command_active = 1'b0, flash_request = 1'b0;
  logic [3:0] gnd_addr = 4'h0, address_straps, strap_address;
  logic [1:0] gnd_start = 2'h0, spin_mode;
  logic delayed_start_strap, remote_start_strap, seated_sense_n, straps_valid, motor_spin_en, activity_indicator_out_n;
  int fail_count = 0, total_checks = 0, n;
  logic seated = 1'b1;
  always #10 clk_sys = ~clk_sys;
  dssd_backplane i_plane (.gnd_addr, .gnd_start, .address_straps, .delayed_start_strap, .remote_start_strap,
    .seated, .seated_sense_n);
  dssd_top #(.SEAT_DELAY_CYC(10), .SPIN_STEP_CYC(5), .FLASH_HALF_CYC(4)) i_dut (.clk_sys, .reset_n, .address_straps,
    .delayed_start_strap, .remote_start_strap, .seated_sense_n, .start_unit_cmd, .command_active, .flash_request,
    .strap_address, .spin_mode, .straps_valid, .motor_spin_en, .activity_indicator_out_n);
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want) begin
      fail_count++;
      $display("[FAIL] %0t got %0h want %0h", $time, got, want);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  // Strap 3 grounded must still give a narrow address
  task automatic boot(input logic [3:0] a, input logic [1:0] s, input logic [2:0] want);
    reset_n = 1'b0;
    gnd_addr = a;
    gnd_start = s;
    step(10);
    check({straps_valid, motor_spin_en, activity_indicator_out_n}, 3'h1);
    reset_n = 1'b1;
    for (n = 0; n < 40 && straps_valid !== 1'b1; n++) step(1);
    // Two sync flops, one cycle to see the seat, then the settle count of 10
    check(n, 13);
    check({strap_address, spin_mode, motor_spin_en}, {1'b0, a[2:0], want});
  endtask
  task automatic t_immediate();
    boot(4'h5, 2'h0, 3'h1);
  endtask
  task automatic t_command(input logic [1:0] s);
    boot(4'hA, s, 3'h2);
    start_unit_cmd = 1'b1;
    step(1);
    start_unit_cmd = 1'b0;
    check(motor_spin_en, 1'b1);
  endtask
  task automatic t_delayed();
    boot(4'h3, 2'h2, 3'h4);
    start_unit_cmd = 1'b1;
    for (n = 0; n < 60 && motor_spin_en !== 1'b1; n++) step(1);
    start_unit_cmd = 1'b0;
    check(n, 16);
  endtask
  task automatic t_lamp();
    boot(4'h0, 2'h1, 3'h2);
    command_active = 1'b1;
    step(1);
    check(activity_indicator_out_n, 1'b0);
    command_active = 1'b0;
    flash_request = 1'b1;
    step(2);
    check(activity_indicator_out_n, 1'b1);
    step(4);
    check(activity_indicator_out_n, 1'b0);
    flash_request = 1'b0;
    step(2);
    check(activity_indicator_out_n, 1'b1);
  endtask
  // Unseated slot never latches; a seat bounce restarts the settle wait
  task automatic t_seat();
    reset_n = 1'b0;
    seated = 1'b0;
    gnd_addr = 4'h6;
    gnd_start = 2'h0;
    step(10);
    reset_n = 1'b1;
    step(30);
    check({straps_valid, motor_spin_en}, 2'h0);
    seated = 1'b1;
    step(8);
    seated = 1'b0;
    step(4);
    seated = 1'b1;
    for (n = 0; n < 40 && straps_valid !== 1'b1; n++) step(1);
    check(n, 13);
    check({strap_address, spin_mode, motor_spin_en}, {4'h6, 2'h0, 1'b1});
  endtask
  task automatic results();
    $display("checks %0d fails %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #60000;
    fail_count++;
    results();
  end
  initial begin
    t_immediate();
    t_command(2'h1);
    t_command(2'h3);
    t_delayed();
    t_lamp();
    t_seat();
    results();
  end
endmodule // test_drive_spinup_strap_decoder
`default_nettype wire
